// [common/apmsc_map.svh]
// Offsets, codes and timing counts for the amplifier power-mode block
`ifndef APMSC_MAP_SVH
`define APMSC_MAP_SVH

`define APMSC_CLK_HZ 50000000
`define APMSC_ZERO_RUN_LEN 12'hFFF
`define APMSC_ZERO_RUN_LAST 12'h7FF
`define APMSC_ADDR_GND 7'h14
`define APMSC_ADDR_OPEN 7'h15
`define APMSC_ADDR_PULL 7'h16
`define APMSC_ADDR_TIED 7'h17
`define APMSC_SLOT_GND 3'h1
`define APMSC_SLOT_OPEN 3'h2
`define APMSC_SLOT_PULL 3'h3
`define APMSC_SLOT_TIED 3'h4
`define APMSC_CLK_LOSS_NS 2000
`define APMSC_CLK_LOSS_CYC ((`APMSC_CLK_LOSS_NS * (`APMSC_CLK_HZ / 1000000)) / 1000)
`define APMSC_PWRUP_NS 1000
`define APMSC_PWRUP_CYC ((`APMSC_PWRUP_NS * (`APMSC_CLK_HZ / 1000000)) / 1000)

`endif

// [common/apmsc_pkg.sv]
// Types for the amplifier power-mode block
package apmsc_pkg;
  typedef enum logic [1:0] {
    APMSC_STRAP_GND,
    APMSC_STRAP_OPEN,
    APMSC_STRAP_PULL,
    APMSC_STRAP_TIED
  } apmsc_strap_t;

  typedef enum logic [2:0] {
    APMSC_ST_OFF,
    APMSC_ST_POWERUP,
    APMSC_ST_ACTIVE,
    APMSC_ST_CLK_SLEEP,
    APMSC_ST_ZERO_SLEEP,
    APMSC_ST_SHUTDOWN
  } apmsc_state_t;
endpackage

// [verilog/apmsc_ratio_check.sv]
// Bit clock to sample ratio measurement and check
`timescale 1ns/1ps
`include "apmsc_map.svh"
module apmsc_ratio_check
  import apmsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Synchronised edges
  input wire logic bclk_rise_i,
  input wire logic frame_sync_in_rise_i,
  // Result
  output logic [9:0] ratio_o,
  output logic ratio_ok_o
);
  logic [9:0] count_r;
  logic ok_nxt;
  localparam logic [9:0] RATIOS [10] = '{10'h032, 10'h040, 10'h064, 10'h080, 10'h0C0,
    10'h0C8, 10'h100, 10'h180, 10'h190, 10'h200};
  logic [9:0] hit;

  ////////////////////////////////////////////////////////////////////////
  // Bit clocks per frame
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      count_r <= 10'h000;
    else if (frame_sync_in_rise_i)
      count_r <= {9'h000, bclk_rise_i};
    else if (bclk_rise_i && count_r != 10'h3FF)
      count_r <= count_r + 10'h001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare against supported ratios
  genvar g;
  generate
    for (g = 0; g < 10; g++)
    begin : g_ratio
      assign hit[g] = (count_r == RATIOS[g]);
    end
  endgenerate

  assign ok_nxt = |hit;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ratio_o <= 10'h000;
      ratio_ok_o <= 1'b0;
    end
    else if (frame_sync_in_rise_i)
    begin
      ratio_o <= count_r;
      ratio_ok_o <= ok_nxt;
    end
  end
endmodule

// [verilog/apmsc_power_ctrl.sv]
// Power-state sequencing and strap decoding for the amplifier
`timescale 1ns/1ps
`include "apmsc_map.svh"
module apmsc_power_ctrl
  import apmsc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Software control bits
  input wire logic full_shutdown_bit_i,
  input wire logic zero_run_sleep_enable_i,
  input wire logic two_wire_mode_i,
  input wire logic [1:0] sample_rate_sel_i,
  // Audio pins
  input wire logic bclk_i,
  input wire logic frame_sync_in_i,
  input wire logic serial_audio_in_i,
  // Decoded sample from the serial receiver
  input wire logic sample_valid_i,
  input wire logic sample_zero_i,
  // Straps and supply status
  input wire logic reg_en_strap_i,
  input wire logic [1:0] addr_strap_i,
  input wire logic core_supply_good_i,
  // Control bus gating
  input wire logic ctrl_bus_req_i,
  output logic ctrl_bus_accept_o,
  // Power domain enables
  output logic core_reg_en_o,
  output logic ctrl_bus_en_o,
  output logic audio_in_en_o,
  output logic analog_en_o,
  output logic power_stage_en_o,
  // Configuration and status
  output logic [6:0] dev_addr_o,
  output logic [2:0] tdm_slot_o,
  output logic [2:0] state_o,
  output logic [9:0] bclk_ratio_o,
  output logic bclk_ratio_ok_o,
  output logic [1:0] sample_rate_o
);
  logic [1:0] bclk_s_r, fs_s_r, sd_s_r, pg_s_r;
  logic bclk_d_r, fs_d_r;
  logic bclk_rise, fs_rise, clk_seen;
  logic [6:0] loss_cnt_r;
  logic clk_lost_r;
  logic [11:0] zero_cnt_r;
  logic [5:0] pwrup_cnt_r;
  logic strap_taken_r;
  logic reg_en_r;
  logic [2:0] strap_s1_r, strap_s2_r;
  apmsc_state_t state_r, state_nxt;
  logic [9:0] ratio_w;
  logic ratio_ok_w;

  localparam logic [6:0] LOSS_CYC = 7'(`APMSC_CLK_LOSS_CYC);
  localparam logic [5:0] PWRUP_CYC = 6'(`APMSC_PWRUP_CYC);
  localparam logic [11:0] ZERO_LAST = 12'(`APMSC_ZERO_RUN_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      bclk_s_r <= 2'h0;
      fs_s_r <= 2'h0;
      sd_s_r <= 2'h0;
      pg_s_r <= 2'h0;
      bclk_d_r <= 1'b0;
      fs_d_r <= 1'b0;
    end
    else
    begin
      bclk_s_r <= {bclk_s_r[0], bclk_i};
      fs_s_r <= {fs_s_r[0], frame_sync_in_i};
      sd_s_r <= {sd_s_r[0], serial_audio_in_i};
      pg_s_r <= {pg_s_r[0], core_supply_good_i};
      bclk_d_r <= bclk_s_r[1];
      fs_d_r <= fs_s_r[1];
    end
  end

  assign bclk_rise = bclk_s_r[1] & ~bclk_d_r;
  assign fs_rise = fs_s_r[1] & ~fs_d_r;
  assign clk_seen = (bclk_s_r[1] ^ bclk_d_r) | (fs_s_r[1] ^ fs_d_r);

  ////////////////////////////////////////////////////////////////////////
  // Clock presence watch
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      loss_cnt_r <= 7'h00;
      clk_lost_r <= 1'b1;
    end
    else if (clk_seen)
    begin
      loss_cnt_r <= 7'h00;
      clk_lost_r <= 1'b0;
    end
    else if (loss_cnt_r == LOSS_CYC)
      clk_lost_r <= 1'b1;
    else
      loss_cnt_r <= loss_cnt_r + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Zero sample run counter
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      zero_cnt_r <= 12'h000;
    else if (sample_valid_i && !sample_zero_i)
      zero_cnt_r <= 12'h000;
    else if (sample_valid_i && zero_cnt_r != `APMSC_ZERO_RUN_LEN)
      zero_cnt_r <= zero_cnt_r + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Straps, synchronised and caught after reset release
  always_ff @(posedge ref_clk_i)
  begin
    strap_s1_r <= {reg_en_strap_i, addr_strap_i};
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      strap_taken_r <= 1'b0;
      reg_en_r <= 1'b0;
      dev_addr_o <= `APMSC_ADDR_GND;
      tdm_slot_o <= `APMSC_SLOT_GND;
    end
    else if (!strap_taken_r)
    begin
      strap_taken_r <= 1'b1;
      reg_en_r <= strap_s2_r[2];
      unique case (apmsc_strap_t'(strap_s2_r[1:0]))
        APMSC_STRAP_GND:
        begin
          dev_addr_o <= `APMSC_ADDR_GND;
          tdm_slot_o <= `APMSC_SLOT_GND;
        end
        APMSC_STRAP_OPEN:
        begin
          dev_addr_o <= `APMSC_ADDR_OPEN;
          tdm_slot_o <= `APMSC_SLOT_OPEN;
        end
        APMSC_STRAP_PULL:
        begin
          dev_addr_o <= `APMSC_ADDR_PULL;
          tdm_slot_o <= `APMSC_SLOT_PULL;
        end
        APMSC_STRAP_TIED:
        begin
          dev_addr_o <= `APMSC_ADDR_TIED;
          tdm_slot_o <= `APMSC_SLOT_TIED;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      APMSC_ST_OFF:
        if (pg_s_r[1] && strap_taken_r)
          state_nxt = APMSC_ST_POWERUP;
      APMSC_ST_POWERUP:
        if (pwrup_cnt_r == PWRUP_CYC)
          state_nxt = APMSC_ST_ACTIVE;
      APMSC_ST_ACTIVE:
        if (zero_run_sleep_enable_i && zero_cnt_r >= ZERO_LAST && sample_valid_i
            && sample_zero_i)
          state_nxt = APMSC_ST_ZERO_SLEEP;
      APMSC_ST_CLK_SLEEP:
        if (!clk_lost_r)
          state_nxt = APMSC_ST_POWERUP;
      APMSC_ST_ZERO_SLEEP:
        if (!zero_run_sleep_enable_i || (sample_valid_i && !sample_zero_i))
          state_nxt = APMSC_ST_ACTIVE;
      APMSC_ST_SHUTDOWN:
        if (!full_shutdown_bit_i)
          state_nxt = APMSC_ST_POWERUP;
    endcase
    if (state_r != APMSC_ST_OFF && state_r != APMSC_ST_SHUTDOWN && two_wire_mode_i
        && clk_lost_r)
      state_nxt = APMSC_ST_CLK_SLEEP;
    if (state_r != APMSC_ST_OFF && full_shutdown_bit_i)
      state_nxt = APMSC_ST_SHUTDOWN;
    if (!pg_s_r[1])
      state_nxt = APMSC_ST_OFF;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      state_r <= APMSC_ST_OFF;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      pwrup_cnt_r <= 6'h00;
    else if (state_r == APMSC_ST_POWERUP && pwrup_cnt_r != PWRUP_CYC)
      pwrup_cnt_r <= pwrup_cnt_r + 6'h01;
    else if (state_r != APMSC_ST_POWERUP)
      pwrup_cnt_r <= 6'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Domain enables
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      core_reg_en_o <= 1'b0;
      ctrl_bus_en_o <= 1'b0;
      audio_in_en_o <= 1'b0;
      analog_en_o <= 1'b0;
      power_stage_en_o <= 1'b0;
    end
    else
    begin
      core_reg_en_o <= reg_en_r;
      ctrl_bus_en_o <= pg_s_r[1] && state_nxt != APMSC_ST_CLK_SLEEP;
      audio_in_en_o <= state_nxt == APMSC_ST_ACTIVE || state_nxt == APMSC_ST_POWERUP
        || state_nxt == APMSC_ST_ZERO_SLEEP;
      analog_en_o <= state_nxt == APMSC_ST_ACTIVE || state_nxt == APMSC_ST_POWERUP;
      power_stage_en_o <= state_nxt == APMSC_ST_ACTIVE;
    end
  end

  assign ctrl_bus_accept_o = ctrl_bus_req_i & pg_s_r[1] & strap_taken_r;
  assign state_o = 3'(state_r);
  assign sample_rate_o = sample_rate_sel_i;

  ////////////////////////////////////////////////////////////////////////
  // Ratio detection
  apmsc_ratio_check apmsc_ratio_check_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .bclk_rise_i(bclk_rise),
    .frame_sync_in_rise_i(fs_rise),
    .ratio_o(ratio_w),
    .ratio_ok_o(ratio_ok_w)
  );

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      bclk_ratio_o <= 10'h000;
      bclk_ratio_ok_o <= 1'b0;
    end
    else
    begin
      bclk_ratio_o <= ratio_w;
      bclk_ratio_ok_o <= ratio_ok_w && !clk_lost_r;
    end
  end
endmodule

// [tb/apmsc_power_ctrl_assertions.sv]
// Checker for the amplifier power-mode block
`timescale 1ns/1ps
module apmsc_power_ctrl_chk (
  // Clock, reset and inputs
  input wire logic ref_clk_i, rst_n_i, sample_valid_i, sample_zero_i,
  input wire logic reg_en_strap_i, core_supply_good_i, ctrl_bus_req_i,
  input wire logic [1:0] addr_strap_i,
  // Outputs
  input wire logic ctrl_bus_accept_o, core_reg_en_o, ctrl_bus_en_o, bclk_ratio_ok_o,
  input wire logic audio_in_en_o, analog_en_o, power_stage_en_o,
  input wire logic [6:0] dev_addr_o,
  input wire logic [2:0] tdm_slot_o, state_o,
  input wire logic [9:0] bclk_ratio_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_SHUTDOWN_OFF: assert property (
    state_o == 3'h5 |-> !audio_in_en_o && !analog_en_o && !power_stage_en_o)
    else $error("shutdown left a domain on");
  AST_CLK_SLEEP_OFF: assert property (
    state_o == 3'h3 |-> !audio_in_en_o && !analog_en_o && !power_stage_en_o && !ctrl_bus_en_o)
    else $error("clock sleep left a domain on");
  AST_CLK_SLEEP_EXIT: assert property (
    state_o == 3'h3 ##1 state_o != 3'h3 |-> state_o inside {3'h0, 3'h1, 3'h5})
    else $error("clock sleep skipped power-up");
  AST_ZERO_SLEEP_DOMAINS: assert property (
    state_o == 3'h4 |-> audio_in_en_o && !analog_en_o && !power_stage_en_o)
    else $error("zero sleep domains wrong");
  AST_ZERO_SLEEP_ENTRY: assert property (
    state_o == 3'h2 ##1 state_o == 3'h4 |-> $past(sample_valid_i) && $past(sample_zero_i))
    else $error("zero sleep without zero sample");
  AST_ZERO_WAKE: assert property (
    state_o == 3'h4 && sample_valid_i && !sample_zero_i |=> state_o != 3'h4)
    else $error("non-zero sample did not wake");
  AST_REG_STRAP: assert property (
    rst_n_i && $past(rst_n_i, 3) |-> core_reg_en_o == reg_en_strap_i)
    else $error("regulator enable differs from strap");
  AST_BUS_GATE: assert property (
    ctrl_bus_accept_o |-> ctrl_bus_req_i && $past(core_supply_good_i, 2))
    else $error("bus accepted without power-good");
  AST_ADDR: assert property (
    rst_n_i && $past(rst_n_i, 3) |-> dev_addr_o == 7'h14 + addr_strap_i)
    else $error("address differs from strap");
  AST_SLOT: assert property (
    rst_n_i && $past(rst_n_i, 3) |-> tdm_slot_o == 3'h1 + addr_strap_i)
    else $error("slot differs from strap");
  AST_RATIO_OK: assert property (
    bclk_ratio_ok_o |-> bclk_ratio_o inside {10'h032, 10'h040, 10'h064, 10'h080, 10'h0C0,
      10'h0C8, 10'h100, 10'h180, 10'h190, 10'h200})
    else $error("unsupported ratio flagged good");
endmodule
bind apmsc_power_ctrl apmsc_power_ctrl_chk apmsc_power_ctrl_chk_i (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .sample_valid_i(sample_valid_i), .sample_zero_i(sample_zero_i),
  .reg_en_strap_i(reg_en_strap_i), .core_supply_good_i(core_supply_good_i),
  .ctrl_bus_req_i(ctrl_bus_req_i), .addr_strap_i(addr_strap_i),
  .ctrl_bus_accept_o(ctrl_bus_accept_o), .core_reg_en_o(core_reg_en_o),
  .ctrl_bus_en_o(ctrl_bus_en_o), .bclk_ratio_ok_o(bclk_ratio_ok_o),
  .audio_in_en_o(audio_in_en_o), .analog_en_o(analog_en_o),
  .power_stage_en_o(power_stage_en_o), .dev_addr_o(dev_addr_o), .tdm_slot_o(tdm_slot_o),
  .state_o(state_o), .bclk_ratio_o(bclk_ratio_o));

// [tb/apmsc_audio_src.sv]
// Serial audio source model
`timescale 1ns/1ps
module apmsc_audio_src (
  // Clock and controls
  input wire logic ref_clk_i, run_i, zero_i,
  input wire logic [9:0] ratio_i,
  // Audio side
  output logic bclk_o, frame_sync_o, serial_audio_in_o, sample_valid_o, sample_zero_o
);
  logic [1:0] ph;
  logic [9:0] bit_n;
  initial {ph, bit_n, bclk_o, frame_sync_o, serial_audio_in_o, sample_valid_o, sample_zero_o} = '0;
  // Bit clock at a quarter of the reference, still while stopped
  always @(posedge ref_clk_i)
  begin
    ph <= ph + 2'h1;
    serial_audio_in_o <= ~serial_audio_in_o;
    sample_valid_o <= run_i && ph == 2'h0;
    sample_zero_o <= (run_i && ph == 2'h0) ? zero_i : ~sample_zero_o;
    if (!run_i)
    begin
      bclk_o <= 1'b0;
      frame_sync_o <= 1'b0;
    end
    else if (ph[0])
    begin
      bclk_o <= ~bclk_o;
      if (bclk_o)
      begin
        bit_n <= (bit_n + 10'h1 >= ratio_i) ? 10'h000 : bit_n + 10'h1;
        frame_sync_o <= bit_n + 10'h1 >= ratio_i;
      end
    end
  end
endmodule

// [tb/test_amp_power_mode_and_strap_control.sv]
// Testbench for the amplifier power-mode block
`timescale 1ns/1ps
module test_amp_power_mode_and_strap_control;
  logic ref_clk_i, rst_n_i, shut, zen, two_wire, pg, req, reg_strap, run, zero;
  logic [1:0] rate, astrap;
  logic [9:0] ratio;
  wire logic bclk, fs, sd, sv, sz, acc, creg, cben, aen, anen, psen, rok;
  wire logic [6:0] addr;
  wire logic [2:0] slot, st;
  wire logic [9:0] rat;
  wire logic [1:0] rate_o;
  logic [9:0] rl [10] = '{10'h032, 10'h040, 10'h064, 10'h080, 10'h0C0, 10'h0C8, 10'h100,
    10'h180, 10'h190, 10'h200};
  int fails = 0;
  int tests_run = 0;
  apmsc_power_ctrl apmsc_power_ctrl_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .full_shutdown_bit_i(shut), .zero_run_sleep_enable_i(zen), .two_wire_mode_i(two_wire),
    .sample_rate_sel_i(rate), .bclk_i(bclk), .frame_sync_in_i(fs), .serial_audio_in_i(sd),
    .sample_valid_i(sv), .sample_zero_i(sz), .reg_en_strap_i(reg_strap),
    .addr_strap_i(astrap), .core_supply_good_i(pg), .ctrl_bus_req_i(req),
    .ctrl_bus_accept_o(acc), .core_reg_en_o(creg), .ctrl_bus_en_o(cben),
    .audio_in_en_o(aen), .analog_en_o(anen), .power_stage_en_o(psen), .dev_addr_o(addr),
    .tdm_slot_o(slot), .state_o(st), .bclk_ratio_o(rat), .bclk_ratio_ok_o(rok),
    .sample_rate_o(rate_o));
  apmsc_audio_src apmsc_audio_src_i (.ref_clk_i(ref_clk_i), .run_i(run), .zero_i(zero),
    .ratio_i(ratio), .bclk_o(bclk), .frame_sync_o(fs), .serial_audio_in_o(sd), .sample_valid_o(sv),
    .sample_zero_o(sz));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(string nm, logic [9:0] exp, logic [9:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wait_st(logic [2:0] s);
    int n;
    n = 0;
    while (st !== s && n < 400)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("state", 10'(s), 10'(st));
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge ref_clk_i);
    fails++;
    conclude();
  end
  initial
  begin
    {rst_n_i, shut, zen, two_wire, pg, reg_strap, zero, astrap} = '0;
    {req, run, rate, ratio} = {1'b1, 1'b1, 2'h2, 10'h040};
    for (int s = 0; s < 4; s++)
    begin
      @(negedge ref_clk_i);
      rst_n_i = 1'b0;
      astrap = 2'(s);
      reg_strap = s[0];
      repeat (4) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      chk("addr", 10'(7'h14 + s), 10'(addr));
      chk("slot", 10'(3'h1 + s), 10'(slot));
      chk("reg_en", 10'(s[0]), 10'(creg));
      chk("accept", 10'h000, 10'(acc));
    end
    $display("strap test done");
    pg = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk("accept", 10'h001, 10'(acc));
    wait_st(3'h2);
    chk("stage", 10'h001, 10'(psen));
    chk("rate", 10'(rate), 10'(rate_o));
    for (int i = 0; i < 11; i++)
    begin
      ratio = (i < 10) ? rl[i] : 10'h041;
      repeat (12 * int'(ratio)) @(negedge ref_clk_i);
      chk("ratio", ratio, rat);
      chk("ratio_ok", 10'(i < 10), 10'(rok));
    end
    $display("ratio test done");
    zen = 1'b1;
    zero = 1'b1;
    repeat (8160) @(negedge ref_clk_i);
    chk("state", 10'h002, 10'(st));
    wait_st(3'h4);
    chk("audio_en", 10'h001, 10'(aen));
    chk("analog_en", 10'h000, 10'(anen));
    zero = 1'b0;
    wait_st(3'h2);
    $display("zero sleep test done");
    zen = 1'b0;
    two_wire = 1'b1;
    run = 1'b0;
    wait_st(3'h3);
    chk("audio_en", 10'h000, 10'(aen));
    run = 1'b1;
    wait_st(3'h1);
    wait_st(3'h2);
    $display("clock loss test done");
    shut = 1'b1;
    wait_st(3'h5);
    chk("bus_en", 10'h001, 10'(cben));
    chk("core_reg", 10'h001, 10'(creg));
    chk("stage", 10'h000, 10'(psen));
    shut = 1'b0;
    wait_st(3'h2);
    $display("shutdown test done");
    conclude();
  end
endmodule
